/* File: hdl/io_pin_drive_mode_port.sv */
// port of 2 to 8 pins (8 by default): drive modes, readback, edge interrupts, reset state
`include "io_port_params.svh"
module io_pin_drive_mode_port #(
   parameter int PINS = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // per-port writes
   input wire logic port_wr,
   input wire logic [3*PINS-1:0] port_mode_wdata,
   input wire logic [PINS-1:0] output_value_write,
   input wire logic [PINS-1:0] port_bypass_wdata,
   input wire logic [2*PINS-1:0] port_edge_wdata,
   // per-pin write
   input wire logic pin_wr,
   input wire logic [$clog2(PINS)-1:0] pin_sel,
   input wire logic [7:0] pin_ctrl_wdata,
   // programmable reset state
   input wire logic rst_state_wr,
   input wire logic [3*PINS-1:0] rst_mode_wdata,
   input wire logic [PINS-1:0] rst_value_wdata,
   // status clear, write one to clear
   input wire logic [PINS-1:0] status_clr,
   // routed signals and pad
   input wire logic [PINS-1:0] routed_out,
   input wire logic [PINS-1:0] regulated_mode,
   input wire logic [PINS-1:0] pad_in,
   // pad controls
   output logic [PINS-1:0] pad_strong_hi,
   output logic [PINS-1:0] pad_strong_lo,
   output logic [PINS-1:0] pad_res_up,
   output logic [PINS-1:0] pad_res_dn,
   // readback and interrupt
   output logic [3*PINS-1:0] pin_drive_mode_select,
   output logic [PINS-1:0] port_output_value,
   output logic [PINS-1:0] pin_state_readback,
   output logic [PINS-1:0] routed_in,
   output logic [PINS-1:0] irq_status,
   output logic port_irq
);
   initial begin
      if (PINS < 2 || PINS > 8) $error("PINS must lie in 2..8");
   end

   typedef struct packed {
      io_port_pkg::port_state_e st;
      logic [3*PINS-1:0] mode;
      logic [PINS-1:0] outv;
      logic [PINS-1:0] byp;
      logic [2*PINS-1:0] edg;
      logic [3*PINS-1:0] rmode;
      logic [PINS-1:0] rval;
      logic [PINS-1:0] sync1;
      logic [PINS-1:0] sync2;
      logic [PINS-1:0] prev;
      logic [PINS-1:0] inen;
      logic [PINS-1:0] ps;
      logic [PINS-1:0] stat;
      logic irq;
      logic [PINS-1:0] shi;
      logic [PINS-1:0] slo;
      logic [PINS-1:0] rup;
      logic [PINS-1:0] rdn;
   } port_s;

   port_s s_reg;
   port_s s_next;
   logic [PINS-1:0] hit;
   logic [PINS-1:0] data;
   logic [PINS-1:0] w_shi;
   logic [PINS-1:0] w_slo;
   logic [PINS-1:0] w_rup;
   logic [PINS-1:0] w_rdn;
   logic [PINS-1:0] w_inen;

   // one bit per pin whose mode field equals the given code
   function automatic logic [PINS-1:0] mode_is(input logic [3*PINS-1:0] mv,
      input logic [2:0] code);
      logic [PINS-1:0] r;
      r = '0;
      for (int i = 0; i < PINS; i++) begin
         r[i] = (mv[3*i +: 3] == code);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // driven value and per-pin decode
   assign data = (s_reg.byp & routed_out) | (~s_reg.byp & s_reg.outv);

   for (genvar g = 0; g < PINS; g++) begin : g_pin
      pin_drive u_drv (
         .drive_mode_bits(s_reg.mode[3*g +: 3]),
         .data(data[g]),
         .regulated(regulated_mode[g]),
         .strong_hi(w_shi[g]),
         .strong_lo(w_slo[g]),
         .res_up(w_rup[g]),
         .res_dn(w_rdn[g]),
         .in_buf_en(w_inen[g])
      );
   end

   edge_detect #(.WIDTH(PINS)) u_edge (
      .cur(s_reg.sync2),
      .prev(s_reg.prev),
      .edge_sel(s_reg.edg),
      .hit(hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      s_next = s_reg;
      s_next.st = io_port_pkg::ST_RUN;
      if (port_wr) begin
         s_next.mode = port_mode_wdata;
         s_next.outv = output_value_write;
         s_next.byp = port_bypass_wdata;
         s_next.edg = port_edge_wdata;
      end
      if (pin_wr) begin
         // one write sets mode, value, bypass and edge of a single pin
         s_next.mode[3*pin_sel +: 3] = pin_ctrl_wdata[`PB_DM_LO +: 3];
         s_next.outv[pin_sel] = pin_ctrl_wdata[`PB_OUT];
         s_next.byp[pin_sel] = pin_ctrl_wdata[`PB_BYP];
         s_next.edg[2*pin_sel +: 2] = pin_ctrl_wdata[`PB_EDGE_LO +: 2];
      end
      if (rst_state_wr) begin
         s_next.rmode = rst_mode_wdata;
         s_next.rval = rst_value_wdata;
      end
      // first stage read only by second stage
      s_next.sync1 = pad_in;
      s_next.sync2 = s_reg.sync1;
      s_next.prev = s_reg.sync2;
      s_next.inen = w_inen;
      // disabled input buffer reads zero and cannot fire
      s_next.ps = s_reg.sync2 & s_reg.inen;
      // set wins over clear
      s_next.stat = (s_reg.stat & ~status_clr) | (hit & s_reg.inen);
      s_next.irq = |s_next.stat;
      s_next.shi = w_shi;
      s_next.slo = w_slo;
      s_next.rup = w_rup;
      s_next.rdn = w_rdn;
      if (s_reg.st == io_port_pkg::ST_RESET) begin
         // after reset, load the programmed port state
         s_next.mode = s_reg.rmode;
         s_next.outv = s_reg.rval;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         // reset keeps programmed reset state, pads go analog
         s_reg <= '0;
         s_reg.st <= io_port_pkg::ST_RESET;
         s_reg.rmode <= s_reg.rmode;
         s_reg.rval <= s_reg.rval;
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign pad_strong_hi = s_reg.shi;
   assign pad_strong_lo = s_reg.slo;
   assign pad_res_up = s_reg.rup;
   assign pad_res_dn = s_reg.rdn;
   assign pin_drive_mode_select = s_reg.mode;
   assign port_output_value = s_reg.outv;
   assign pin_state_readback = s_reg.ps;
   assign routed_in = s_reg.ps;
   assign irq_status = s_reg.stat;
   assign port_irq = s_reg.irq;

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   reset_mode_a: assert property ($rose(nrst) |-> s_reg.mode == '0)
      else $error("mode not analog after reset");
   edge_status_a: assert property (|(hit & s_reg.inen) |=> |(irq_status))
      else $error("edge did not set status");
   irq_follow_a: assert property (port_irq == |irq_status)
      else $error("port irq disagrees with status");
   readback_sep_a: assert property (!port_wr && !pin_wr && s_reg.st != io_port_pkg::ST_RESET
      |=> $stable(port_output_value))
      else $error("output value changed without write");
   port_write_a: assert property (port_wr && !pin_wr |=> port_output_value == $past(output_value_write))
      else $error("port write lost");
   analog_input_a: assert property (s_reg.inen == '0 |=> pin_state_readback == '0)
      else $error("analog pin gave input");
   no_fight_a: assert property ((pad_strong_hi & pad_strong_lo) == '0)
      else $error("pad driven both ways");
   sync_delay_a: assert property (!$stable(pad_in) |-> ##3 s_reg.prev == $past(pad_in, 3))
      else $error("sync chain length wrong");
   // pad controls lag the mode by one register, hence the past masks
   analog_off_a: assert property (|$past(mode_is(s_reg.mode, `DM_HIZ_ANALOG))
      |-> ((pad_strong_hi | pad_strong_lo | pad_res_up | pad_res_dn)
      & $past(mode_is(s_reg.mode, `DM_HIZ_ANALOG))) == '0)
      else $error("analog pin drives pad");
   digital_hiz_a: assert property (|$past(mode_is(s_reg.mode, `DM_HIZ_DIGITAL))
      |-> ((pad_strong_hi | pad_strong_lo | pad_res_up | pad_res_dn)
      & $past(mode_is(s_reg.mode, `DM_HIZ_DIGITAL))) == '0)
      else $error("high impedance pin drives pad");
   od_low_a: assert property (|$past(mode_is(s_reg.mode, `DM_OD_LOW))
      |-> ((pad_strong_hi | pad_res_up | pad_res_dn)
      & $past(mode_is(s_reg.mode, `DM_OD_LOW))) == '0)
      else $error("open drain low drives high");
   od_high_a: assert property (|$past(mode_is(s_reg.mode, `DM_OD_HIGH))
      |-> ((pad_strong_lo | pad_res_up | pad_res_dn)
      & $past(mode_is(s_reg.mode, `DM_OD_HIGH))) == '0)
      else $error("open drain high drives low");
   strong_push_a: assert property (|$past(mode_is(s_reg.mode, `DM_STRONG))
      |-> (~(pad_strong_hi | pad_strong_lo) & $past(mode_is(s_reg.mode, `DM_STRONG))) == '0)
      else $error("strong pin not driven");
   res_both_a: assert property (|$past(mode_is(s_reg.mode, `DM_RES_BOTH) & ~regulated_mode)
      |-> (~(pad_res_up | pad_res_dn)
      & $past(mode_is(s_reg.mode, `DM_RES_BOTH) & ~regulated_mode)) == '0)
      else $error("resistive pin not pulled");
   regulated_res_a: assert property (|$past(regulated_mode)
      |-> ((pad_res_up | pad_res_dn) & $past(regulated_mode)) == '0)
      else $error("resistor on regulated pin");
   no_level_a: assert property (((irq_status & ~$past(irq_status))
      & ~$past(hit & s_reg.inen)) == '0)
      else $error("status set without edge");
   pin_form_a: assert property (pin_wr && s_reg.st != io_port_pkg::ST_RESET
      |=> pin_drive_mode_select[3*$past(pin_sel) +: 3] == $past(pin_ctrl_wdata[`PB_DM_LO +: 3]))
      else $error("pin form write lost");
   cov_irq_c: cover property ($rose(port_irq));
   cov_pin_c: cover property (pin_wr);
   cov_byp_c: cover property (|s_reg.byp && port_irq);
endmodule

/* File: hdl/io_port_params.svh */
// mode, edge and control byte constants for the pin drive mode port
`ifndef IO_PORT_PARAMS_SVH
`define IO_PORT_PARAMS_SVH
`define DM_HIZ_ANALOG 3'h0
`define DM_HIZ_DIGITAL 3'h1
`define DM_RES_UP 3'h2
`define DM_RES_DOWN 3'h3
`define DM_OD_LOW 3'h4
`define DM_OD_HIGH 3'h5
`define DM_STRONG 3'h6
`define DM_RES_BOTH 3'h7
`define EDGE_NONE 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
// per-pin control byte layout
`define PB_DM_LO 0
`define PB_OUT 3
`define PB_BYP 4
`define PB_EDGE_LO 5
`define PB_INEN 7
`endif

/* File: hdl/io_port_pkg.sv */
// types for the pin drive mode port
package io_port_pkg;
   typedef logic [2:0] drive_mode_t;
   typedef logic [1:0] edge_sel_t;
   typedef enum logic [2:0] {
      ST_RESET = 3'h1,
      ST_RUN = 3'h2,
      ST_HOLD = 3'h4
   } port_state_e;
endpackage

/* File: hdl/pin_drive.sv */
// combinational drive decode of one pin from its mode and data
`include "io_port_params.svh"
module pin_drive (
   // mode and data
   input wire logic [2:0] drive_mode_bits,
   input wire logic data,
   input wire logic regulated,
   // pad controls
   output logic strong_hi,
   output logic strong_lo,
   output logic res_up,
   output logic res_dn,
   output logic in_buf_en
);
   logic [2:0] m;
   always_comb begin
      // regulated special pins in a resistive mode fall back to high impedance digital
      m = drive_mode_bits;
      if (regulated && (m == `DM_RES_UP || m == `DM_RES_DOWN || m == `DM_RES_BOTH)) begin
         m = `DM_HIZ_DIGITAL;
      end
      strong_hi = 1'b0;
      strong_lo = 1'b0;
      res_up = 1'b0;
      res_dn = 1'b0;
      in_buf_en = (m != `DM_HIZ_ANALOG);
      case (m)
         `DM_RES_UP: begin
            res_up = data;
            strong_lo = !data;
         end
         `DM_RES_DOWN: begin
            strong_hi = data;
            res_dn = !data;
         end
         `DM_OD_LOW: strong_lo = !data;
         `DM_OD_HIGH: strong_hi = data;
         `DM_STRONG: begin
            strong_hi = data;
            strong_lo = !data;
         end
         `DM_RES_BOTH: begin
            res_up = data;
            res_dn = !data;
         end
         default: ;
      endcase
   end
endmodule

/* File: hdl/edge_detect.sv */
// per-pin edge selection on already synchronised samples
`include "io_port_params.svh"
module edge_detect #(
   parameter int WIDTH = 8
) (
   // samples
   input wire logic [WIDTH-1:0] cur,
   input wire logic [WIDTH-1:0] prev,
   input wire logic [2*WIDTH-1:0] edge_sel,
   // events
   output logic [WIDTH-1:0] hit
);
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         // only transitions count: a steady level never fires
         hit[i] = 1'b0;
         case (edge_sel[2*i +: 2])
            `EDGE_RISE: hit[i] = cur[i] & !prev[i];
            `EDGE_FALL: hit[i] = !cur[i] & prev[i];
            `EDGE_BOTH: hit[i] = cur[i] ^ prev[i];
            default: hit[i] = 1'b0;
         endcase
      end
   end
endmodule

/* File: test/pad_model.sv */
// board-side pad model: resolves device drivers against an external source
module pad_model #(
   parameter int PINS = 8
) (
   // clock
   input wire logic clk,
   // device pad controls
   input wire logic [PINS-1:0] strong_hi,
   input wire logic [PINS-1:0] strong_lo,
   input wire logic [PINS-1:0] res_up,
   input wire logic [PINS-1:0] res_dn,
   // external source
   input wire logic [PINS-1:0] ext_en,
   input wire logic [PINS-1:0] ext_val,
   // resolved level
   output logic [PINS-1:0] pad_level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [PINS-1:0] float_pat = '0;
   ////////////////////////////////////////////////////////////
   // a floating pad must not look steady, so it toggles every cycle
   always @(negedge clk) begin
      float_pat <= ~float_pat;
   end
   // strong beats external, external beats resistors
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (strong_hi[i]) pad_level[i] = 1'b1;
         else if (strong_lo[i]) pad_level[i] = 1'b0;
         else if (ext_en[i]) pad_level[i] = ext_val[i];
         else if (res_up[i]) pad_level[i] = 1'b1;
         else if (res_dn[i]) pad_level[i] = 1'b0;
         else pad_level[i] = float_pat[i];
      end
   end
endmodule

/* File: test/io_pin_drive_mode_port_tb_top.sv */
// self-checking bench for the pin drive mode port
module io_pin_drive_mode_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, nrst = 1'b0, port_wr = 1'b0, pin_wr = 1'b0, rst_state_wr = 1'b0;
   logic pin_go = 1'b0, port_irq;
   logic [23:0] port_mode_wdata = '0, rst_mode_wdata = '0, pin_drive_mode_select;
   logic [15:0] port_edge_wdata = '0;
   logic [7:0] output_value_write = '0, port_bypass_wdata = '0, pin_ctrl_wdata = '0;
   logic [7:0] rst_value_wdata = '0, status_clr = '0, routed_out = '0, regulated_mode = '0;
   logic [7:0] ext_en = '0, ext_val = '0, pad_in, hi, lo, up, dn, port_output_value;
   logic [7:0] pin_state_readback, routed_in, irq_status, row;
   logic [2:0] pin_sel = 3'h3;
   int fail_count = 0;
   int check_count = 0;
   // mode, data, then expected strong hi, strong lo, res up, res down
   logic [7:0] rows [16] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h44, 8'h52, 8'h61, 8'h78,
      8'h84, 8'h90, 8'hA0, 8'hB8, 8'hC4, 8'hD8, 8'hE1, 8'hF2};
   io_pin_drive_mode_port #(.PINS(8)) u_dut (.clk(clk), .nrst(nrst), .port_wr(port_wr),
      .port_mode_wdata(port_mode_wdata), .output_value_write(output_value_write),
      .port_bypass_wdata(port_bypass_wdata), .port_edge_wdata(port_edge_wdata),
      .pin_wr(pin_wr), .pin_sel(pin_sel), .pin_ctrl_wdata(pin_ctrl_wdata),
      .rst_state_wr(rst_state_wr), .rst_mode_wdata(rst_mode_wdata),
      .rst_value_wdata(rst_value_wdata), .status_clr(status_clr), .routed_out(routed_out),
      .regulated_mode(regulated_mode), .pad_in(pad_in), .pad_strong_hi(hi),
      .pad_strong_lo(lo), .pad_res_up(up), .pad_res_dn(dn),
      .pin_drive_mode_select(pin_drive_mode_select), .port_output_value(port_output_value),
      .pin_state_readback(pin_state_readback), .routed_in(routed_in),
      .irq_status(irq_status), .port_irq(port_irq));
   pad_model #(.PINS(8)) u_pad (.clk(clk), .strong_hi(hi), .strong_lo(lo), .res_up(up),
      .res_dn(dn), .ext_en(ext_en), .ext_val(ext_val), .pad_level(pad_in));
   always #20 clk = ~clk;
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic pads(input logic [7:0] h, input logic [7:0] l, input logic [7:0] u,
      input logic [7:0] d);
      check({hi, lo, up}, {h, l, u}, "pad hi lo up");
      check(24'(dn), 24'(d), "pad res down");
   endtask
   // waits past the longest answer so one task suits every check
   task automatic write(input logic [23:0] m, input logic [7:0] v, input logic [7:0] b,
      input logic [15:0] e);
      @(negedge clk);
      {port_mode_wdata, output_value_write, port_bypass_wdata, port_edge_wdata} = {m, v, b, e};
      port_wr = 1'b1;
      pin_wr = pin_go;
      @(negedge clk);
      port_wr = 1'b0;
      pin_wr = 1'b0;
      repeat (6) @(negedge clk);
   endtask
   task automatic settle(input logic [7:0] clr);
      status_clr = clr;
      @(negedge clk);
      status_clr = '0;
      repeat (6) @(negedge clk);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #160000;
      fail_count++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end
   initial begin
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      repeat (2) @(negedge clk);
      {rst_mode_wdata, rst_value_wdata, rst_state_wr} = {24'hDB6DB6, 8'h0F, 1'b1};
      @(negedge clk);
      rst_state_wr = 1'b0;
      foreach (rows[r]) begin
         row = rows[r];
         write({8{row[7:5]}}, {8{row[4]}}, 8'h00, 16'h0000);
         check(pin_drive_mode_select, {8{row[7:5]}}, "mode select");
         pads({8{row[3]}}, {8{row[2]}}, {8{row[1]}}, {8{row[0]}});
         if (row[7:5] == 3'h0) check(24'(pin_state_readback), 24'h000000, "buffer off");
         else if (row[3:0] != 4'h0) check(24'(pin_state_readback), 24'({8{row[4]}}), "rb");
      end
      regulated_mode = 8'hFF;
      write({8{3'h7}}, 8'hFF, 8'h00, 16'h0000);
      pads(8'h00, 8'h00, 8'h00, 8'h00);
      write({8{3'h2}}, 8'h00, 8'h00, 16'h0000);
      pads(8'h00, 8'h00, 8'h00, 8'h00);
      write({8{3'h6}}, 8'h0F, 8'h00, 16'h0000);
      pads(8'h0F, 8'hF0, 8'h00, 8'h00);
      regulated_mode = 8'h00;
      routed_out = 8'hA5;
      write(24'hDB6DB6, 8'h00, 8'hFF, 16'h0000);
      pads(8'hA5, 8'h5A, 8'h00, 8'h00);
      check({port_output_value, pin_state_readback, routed_in}, 24'h00A5A5, "bypass");
      // pin write and port write land at the same edge; the pin wins
      {pin_go, pin_ctrl_wdata} = {1'b1, 8'h0E};
      write(24'h249249, 8'h00, 8'h00, 16'h0000);
      pin_go = 1'b0;
      check(pin_drive_mode_select, 24'h249C49, "pin form mode");
      check({port_output_value, hi, lo}, 24'h080800, "pin form value");
      {ext_en, ext_val} = {8'hFF, 8'h00};
      write(24'h248249, 8'h00, 8'h00, 16'hE5E4);
      settle(8'hFF);
      ext_val = 8'hFF;
      repeat (6) @(negedge clk);
      check({irq_status, pin_state_readback}, 24'hAAEF, "rise");
      check(24'(port_irq), 24'h000001, "port irq set");
      settle(8'hFF);
      check({irq_status, 7'h00, port_irq}, 24'h0000, "level ignored");
      ext_val = 8'h00;
      repeat (6) @(negedge clk);
      check(24'(irq_status), 24'h0000CC, "fall");
      settle(8'hFF);
      ext_en = 8'h00;
      nrst = 1'b0;
      repeat (12) @(negedge clk);
      check(pin_drive_mode_select, 24'h000000, "in reset");
      check({irq_status, hi, lo}, 24'h000000, "in reset");
      nrst = 1'b1;
      repeat (6) @(negedge clk);
      check(pin_drive_mode_select, 24'hDB6DB6, "reset mode");
      check({port_output_value, hi, lo}, 24'h0F0FF0, "reset value");
      complete_run();
   end
endmodule
